//--- rtl/ebt_timer8.sv
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module ebt_timer8 #(
  parameter int PRESCALE_WIDTH = 8
) (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic demod_input_pin,
  input wire logic alt_input_pin,
  output logic timer_output_pin,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] ctl_reg;
  logic timeout_flag_reg;
  logic [7:0] shared_reg;
  logic capt_flag_reg;
  logic [7:0] load_low_reg;
  logic [7:0] load_high_reg;
  logic [7:0] capture_low_reg;
  logic [7:0] capture_high_reg;
  logic [7:0] count_reg;
  logic running_reg;
  logic timer_out_reg;
  ebt_pkg::ebt_phase_type phase_reg;

  // Bus address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  ebt_pkg::ebt_ctl_type ctl;
  logic demod_mode;
  logic tick;
  logic terminal;
  logic enable_write;
  logic [7:0] divisor;
  logic sel_level;
  logic rise_main;
  logic fall_main;
  logic rise_alt;
  logic fall_alt;
  logic edge_hit;
  logic level_main;
  logic level_alt;
  logic clear_timeout;
  logic clear_capt;
  logic addr_phase;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign ctl.enable = ctl_reg[ebt_pkg::CTL_ENABLE];
  assign ctl.single = ctl_reg[ebt_pkg::CTL_SINGLE];
  assign ctl.clk_sel = ctl_reg[ebt_pkg::CTL_CLK_LO +: 2];
  assign ctl.cap_mask = ctl_reg[ebt_pkg::CTL_CAP_MASK];
  assign ctl.cnt_mask = ctl_reg[ebt_pkg::CTL_CNT_MASK];
  assign ctl.pin_sel = ctl_reg[ebt_pkg::CTL_PIN_SEL];
  assign demod_mode = shared_reg[ebt_pkg::SHR_MODE] != 1'b0;

  // Bus address phase accepted
  assign addr_phase = hsel & hready & htrans[1];
  assign enable_write = wr_pend_reg && wr_addr_reg == ebt_pkg::ADDR_CONTROL
    && hwdata[ebt_pkg::CTL_ENABLE];
  assign clear_timeout = wr_pend_reg && wr_addr_reg == ebt_pkg::ADDR_CONTROL
    && hwdata[ebt_pkg::CTL_TIMEOUT];
  assign clear_capt = wr_pend_reg && wr_addr_reg == ebt_pkg::ADDR_SHARED
    && hwdata[ebt_pkg::SHR_CAPT_FLAG];

  // ----------------------------------------
  // Clock select
  // ----------------------------------------
  always_comb begin
    case (ctl.clk_sel)
      2'h0: divisor = ebt_pkg::DIV_SEL0;
      2'h1: divisor = ebt_pkg::DIV_SEL1;
      2'h2: divisor = ebt_pkg::DIV_SEL2;
      default: divisor = ebt_pkg::DIV_SEL3;
    endcase
  end

  // Prescaler keeps its count while stopped, so the first tick may be partial
  ebt_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(running_reg),
    .divisor(PRESCALE_WIDTH'(divisor)),
    .tick(tick)
  );

  // Edge detectors on both candidate inputs
  ebt_edge_detect u_edge_main (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(demod_input_pin),
    .edge_sel(shared_reg[ebt_pkg::SHR_EDGE_LO +: 2]),
    .level(level_main),
    .rise(rise_main),
    .fall(fall_main)
  );

  ebt_edge_detect u_edge_alt (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(alt_input_pin),
    .edge_sel(shared_reg[ebt_pkg::SHR_EDGE_LO +: 2]),
    .level(level_alt),
    .rise(rise_alt),
    .fall(fall_alt)
  );

  // Input source choice; demod pin when select is zero
  assign sel_level = shared_reg[ebt_pkg::SHR_DEMOD_SEL] ? level_alt : level_main;
  assign edge_hit = demod_mode && running_reg && (shared_reg[ebt_pkg::SHR_DEMOD_SEL]
    ? (rise_alt | fall_alt) : (rise_main | fall_main));

  // Terminal count in waveform mode
  assign terminal = running_reg && tick && !demod_mode && count_reg == ebt_pkg::COUNT_ONE;

  // ----------------------------------------
  // AHB-Lite write address phase
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= ebt_pkg::BYTE_ZERO;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // Zero-wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data, registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        ebt_pkg::ADDR_CONTROL: begin
          hrdata <= {24'h000000, ctl_reg[7:6], timeout_flag_reg, ctl_reg[4:0]};
        end
        ebt_pkg::ADDR_SHARED: begin
          hrdata <= {24'h000000, shared_reg[7:3], sel_level, capt_flag_reg, shared_reg[0]};
        end
        ebt_pkg::ADDR_LOAD_LOW: hrdata <= {24'h000000, load_low_reg};
        ebt_pkg::ADDR_LOAD_HIGH: hrdata <= {24'h000000, load_high_reg};
        ebt_pkg::ADDR_CAPT_LOW: hrdata <= {24'h000000, capture_low_reg};
        ebt_pkg::ADDR_CAPT_HIGH: hrdata <= {24'h000000, capture_high_reg};
        ebt_pkg::ADDR_COUNT: hrdata <= {24'h000000, count_reg};
        default: hrdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= ebt_pkg::CTL_RESET;
      shared_reg <= ebt_pkg::SHR_RESET;
      load_low_reg <= ebt_pkg::BYTE_ZERO;
      load_high_reg <= ebt_pkg::BYTE_ZERO;
    end else begin
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          ebt_pkg::ADDR_CONTROL: ctl_reg <= hwdata[7:0];
          ebt_pkg::ADDR_SHARED: shared_reg <= hwdata[7:0];
          ebt_pkg::ADDR_LOAD_LOW: load_low_reg <= hwdata[7:0];
          ebt_pkg::ADDR_LOAD_HIGH: load_high_reg <= hwdata[7:0];
          default: ;
        endcase
      end
      // Single pass clears enable on completion
      if (terminal && ctl.single) begin
        ctl_reg[ebt_pkg::CTL_ENABLE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_flag_reg <= 1'b0;
      capt_flag_reg <= 1'b0;
    end else begin
      if (terminal) begin
        timeout_flag_reg <= 1'b1;
      end else if (clear_timeout) begin
        timeout_flag_reg <= 1'b0;
      end
      if (edge_hit) begin
        capt_flag_reg <= 1'b1;
      end else if (clear_capt) begin
        capt_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Counter and output
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= ebt_pkg::BYTE_ZERO;
      running_reg <= 1'b0;
      phase_reg <= ebt_pkg::EBT_LOW_PHASE;
      timer_out_reg <= 1'b0;
    end else if (enable_write) begin
      running_reg <= 1'b1;
      count_reg <= load_low_reg;
      phase_reg <= ebt_pkg::EBT_LOW_PHASE;
      timer_out_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == ebt_pkg::ADDR_CONTROL) begin
      running_reg <= 1'b0;
    end else if (demod_mode && tick) begin
      count_reg <= count_reg + 8'h01;
    end else if (terminal) begin
      if (ctl.single) begin
        running_reg <= 1'b0;
      end else begin
        case (phase_reg)
          ebt_pkg::EBT_LOW_PHASE: begin
            phase_reg <= ebt_pkg::EBT_HIGH_PHASE;
            count_reg <= load_high_reg;
          end
          ebt_pkg::EBT_HIGH_PHASE: begin
            phase_reg <= ebt_pkg::EBT_LOW_PHASE;
            count_reg <= load_low_reg;
          end
          default: phase_reg <= ebt_pkg::EBT_LOW_PHASE;
        endcase
      end
      timer_out_reg <= ~timer_out_reg;
    end else if (running_reg && tick) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // Capture count on edges in demod_capture_mode mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_low_reg <= ebt_pkg::BYTE_ZERO;
      capture_high_reg <= ebt_pkg::BYTE_ZERO;
    end else if (edge_hit) begin
      if (sel_level) begin
        capture_low_reg <= count_reg;
      end else begin
        capture_high_reg <= count_reg;
      end
    end
  end

  // Output pin mux registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
    end else if (ctl.pin_sel && !demod_mode) begin
      timer_output_pin <= timer_out_reg;
    end else begin
      timer_output_pin <= shared_reg[ebt_pkg::SHR_PIN_LATCH];
    end
  end

  // Interrupt while flag and mask both set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (timeout_flag_reg & ctl.cnt_mask)
        | (capt_flag_reg & ctl.cap_mask);
    end
  end

endmodule

//--- rtl/ebt_pkg.sv
package ebt_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SHARED = 8'h04;
  localparam logic [7:0] ADDR_LOAD_LOW = 8'h08;
  localparam logic [7:0] ADDR_LOAD_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_CAPT_LOW = 8'h10;
  localparam logic [7:0] ADDR_CAPT_HIGH = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;

  // ----------------------------------------
  // Control register field positions
  // ----------------------------------------
  localparam int CTL_ENABLE = 7;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_TIMEOUT = 5;
  localparam int CTL_CLK_LO = 3;
  localparam int CTL_CAP_MASK = 2;
  localparam int CTL_CNT_MASK = 1;
  localparam int CTL_PIN_SEL = 0;

  // Shared register field positions
  localparam int SHR_MODE = 7;
  localparam int SHR_DEMOD_SEL = 6;
  localparam int SHR_EDGE_HI = 5;
  localparam int SHR_EDGE_LO = 4;
  localparam int SHR_PIN_LATCH = 3;
  localparam int SHR_CAPT_FLAG = 1;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] SHR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------
  // Prescale divisors for clock select
  // ----------------------------------------
  localparam logic [7:0] DIV_SEL0 = 8'h02;
  localparam logic [7:0] DIV_SEL1 = 8'h04;
  localparam logic [7:0] DIV_SEL2 = 8'h08;
  localparam logic [7:0] DIV_SEL3 = 8'h10;

  // Timer phase
  typedef enum logic {
    EBT_LOW_PHASE,
    EBT_HIGH_PHASE
  } ebt_phase_type;

  // Control register decoded
  typedef struct packed {
    logic enable;
    logic single;
    logic [1:0] clk_sel;
    logic cap_mask;
    logic cnt_mask;
    logic pin_sel;
  } ebt_ctl_type;

endpackage

//--- rtl/ebt_prescaler.sv
`timescale 1ns/100ps
// Tick enable divider with selectable divisor
module ebt_prescaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  // Tick
  output logic tick
);

  logic [WIDTH-1:0] count_reg;

  // Divider holds its count while stopped; first tick after start may be short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (count_reg >= divisor - WIDTH'(1)) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + WIDTH'(1);
      tick <= 1'b0;
    end
  end

endmodule

//--- rtl/ebt_edge_detect.sv
`timescale 1ns/100ps
// Synchronised input with selectable edge detection
module ebt_edge_detect (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin and selection
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  // Outputs
  output logic level,
  output logic rise,
  output logic fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  // Two-stage synchroniser then edge compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  assign level = sync2_reg;
  // edge_sel: 00 none, 01 falling, 10 rising, 11 both
  assign rise = edge_sel[1] & sync2_reg & ~last_reg;
  assign fall = edge_sel[0] & ~sync2_reg & last_reg;

endmodule

//--- verif/ebt_assertions.sv
`timescale 1ns/100ps
// Port-level checks of the timer control block
module ebt_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and interrupt
  input wire logic timer_output_pin,
  input wire logic irq
);
  logic ap_wr;
  logic [7:0] ap_addr;
  logic [7:0] ctl_sh;
  logic [7:0] shr_sh;
  logic [1:0] quiet;
  wire logic ap = hsel & hready & htrans[1];
  wire logic dp_wr = ap_wr & hready;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr <= ap & hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  // Shadow of written control bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_sh <= 8'h00;
      shr_sh <= 8'h00;
    end else if (dp_wr && ap_addr == ebt_pkg::ADDR_CONTROL) begin
      ctl_sh <= hwdata[7:0];
    end else if (dp_wr && ap_addr == ebt_pkg::ADDR_SHARED) begin
      shr_sh <= hwdata[7:0];
    end
  end

  // Cycles since the last register write, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet <= 2'h3;
    end else if (dp_wr) begin
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");

  property p_rd_upper;
    hrdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");

  property p_unmapped;
    ap && !hwrite && haddr[7:0] > ebt_pkg::ADDR_COUNT |=> hrdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_pin_latch;
    quiet == 2'h3 && !ctl_sh[ebt_pkg::CTL_PIN_SEL] && !shr_sh[ebt_pkg::SHR_MODE]
      |-> timer_output_pin == shr_sh[ebt_pkg::SHR_PIN_LATCH];
  endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("pin not following latch");

  property p_irq_mask;
    quiet == 2'h3 && ctl_sh[ebt_pkg::CTL_CAP_MASK:ebt_pkg::CTL_CNT_MASK] == 2'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with both masks clear");

  property p_irq_rise;
    $rose(irq) |-> ctl_sh[ebt_pkg::CTL_CAP_MASK] || ctl_sh[ebt_pkg::CTL_CNT_MASK];
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose while masked");

  property p_fall_write;
    $fell(irq) |-> quiet != 2'h3;
  endproperty
  a_fall_write: assert property (p_fall_write) else $error("interrupt fell with no write");

  property p_pin_hold;
    quiet == 2'h3 && ctl_sh[ebt_pkg::CTL_PIN_SEL] && !ctl_sh[ebt_pkg::CTL_ENABLE]
      && !shr_sh[ebt_pkg::SHR_MODE] |=> $stable(timer_output_pin);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("stopped timer output moved");

  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (ap && !hwrite && haddr[7:0] > ebt_pkg::ADDR_COUNT);
  c_pin_hold: cover property (quiet == 2'h3 && ctl_sh[ebt_pkg::CTL_PIN_SEL] && !ctl_sh[ebt_pkg::CTL_ENABLE]);
endmodule

bind ebt_timer8 ebt_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(timer_output_pin), .irq(irq));

//--- verif/test_eight_bit_timer_control.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin tests_run++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_eight_bit_timer_control;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic demod_input_pin = 1'b0;
  logic pin;
  logic irq;
  logic [31:0] rd;
  logic [31:0] hold;
  logic [31:0] seed = 32'h52CCA405;
  int n_fail = 0;
  int tests_run = 0;
  int waited;
  int len;

  // Clock, 20 ns period
  always #10 hclk = ~hclk;

  ebt_timer8 u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .demod_input_pin(demod_input_pin),
    .alt_input_pin(1'b0), .timer_output_pin(pin), .irq(irq));

  // Random source
  function automatic logic [31:0] nxt(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Wait window for terminal count, partial first tick allowed
  function automatic logic in_win(input int w, input int l, input int s);
    int d;
    case (s)
      0: d = ebt_pkg::DIV_SEL0;
      1: d = ebt_pkg::DIV_SEL1;
      2: d = ebt_pkg::DIV_SEL2;
      default: d = ebt_pkg::DIV_SEL3;
    endcase
    return (w >= (l - 1) * d) && (w <= l * d + 4);
  endfunction

  // One single word transfer
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Wait for the interrupt, bounded
  task automatic wait_irq(input int lim);
    waited = 0;
    while (irq !== 1'b1 && waited < lim) begin
      @(negedge hclk);
      waited++;
    end
  endtask

  // Summary and verdict
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
    `CHK("ctl reset", 32'h0, rd)
    xfer(1'b1, 8'h1C, 32'hFF);
    xfer(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // Latch value reaches the pin
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      xfer(1'b1, ebt_pkg::ADDR_SHARED, {28'h0, seed[0], 3'h0});
      repeat (3) @(negedge hclk);
      `CHK("pin latch", seed[0], pin)
    end
    // Every clock select in reload mode
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h01);
    for (int s = 0; s < 4; s++) begin
      seed = nxt(seed);
      len = 2 + seed[2:0];
      xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h21);
      xfer(1'b1, ebt_pkg::ADDR_LOAD_LOW, len);
      xfer(1'b1, ebt_pkg::ADDR_LOAD_HIGH, len);
      // Enable restarts the timer output low; first terminal count drives it high
      xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h83 | (s << 3));
      wait_irq(400);
      `CHK("tick window", 1'b1, in_win(waited, len, s))
      `CHK("pin toggled", 1'b1, pin)
      xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
      `CHK("still running", 32'hA0, rd & 32'hA0)
      xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h03);
      xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
      `CHK("flag kept", 32'h20, rd & 32'h20)
      `CHK("irq held", 1'b1, irq)
      xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h23);
      xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
      `CHK("flag cleared", 32'h0, rd & 32'h20)
      @(negedge hclk);
      `CHK("irq low", 1'b0, irq)
    end
    // Single pass halts
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'hC2);
    wait_irq(100);
    xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
    `CHK("single halts", 32'h20, rd & 32'hA0)
    xfer(1'b0, ebt_pkg::ADDR_COUNT, 32'h0);
    hold = rd;
    repeat (40) @(posedge hclk);
    xfer(1'b0, ebt_pkg::ADDR_COUNT, 32'h0);
    `CHK("count held", hold, rd)
    // Timeout masked off
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h20);
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h80);
    repeat (60) @(negedge hclk);
    `CHK("masked irq", 1'b0, irq)
    xfer(1'b0, ebt_pkg::ADDR_CONTROL, 32'h0);
    `CHK("masked flag", 32'h20, rd & 32'h20)
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h20);
    // Capture on both edges in demod_capture_mode mode
    xfer(1'b1, ebt_pkg::ADDR_SHARED, 32'hB0);
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h84);
    demod_input_pin <= 1'b1;
    wait_irq(20);
    `CHK("capture irq", 1'b1, irq)
    xfer(1'b0, ebt_pkg::ADDR_SHARED, 32'h0);
    `CHK("capture flag", 32'h02, rd & 32'h02)
    xfer(1'b1, ebt_pkg::ADDR_SHARED, 32'hB2);
    repeat (2) @(negedge hclk);
    `CHK("capture cleared", 1'b0, irq)
    xfer(1'b1, ebt_pkg::ADDR_CONTROL, 32'h80);
    demod_input_pin <= 1'b0;
    repeat (10) @(negedge hclk);
    `CHK("capture masked", 1'b0, irq)
    xfer(1'b0, ebt_pkg::ADDR_SHARED, 32'h0);
    `CHK("falling capture", 32'h02, rd & 32'h02)
    conclude();
  end
endmodule
